// ### hdl/plsz_serializer.sv
// Seven-to-one pixel link serializer with forwarded clock and power-down.
// Notes on behaviour
// - Sample all 21 inputs on pixel clock fall.
// - Three serial data channels share the word.
// - Seven bit slots per pixel clock cycle.
// - Slots spaced evenly, one seventh apart; here each slot is SLOT_DIV system clocks, whatever the pixel clock period.
// - Forward link clock on its own pair.
// - Lock within 10 ms of valid pixel clock.
// - Power-down low tristates all serial outputs.
// - Outputs tristate within 100 ns of power-down.
`default_nettype none
module plsz_serializer #(
  parameter int unsigned LOCK_CYCLES = plsz_pkg::PLL_LOCK_CYCLES,
  parameter int unsigned SLOT_DIV    = plsz_pkg::SLOT_DIV,
  parameter int unsigned IDLE_CYCLES = plsz_pkg::IDLE_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // Parallel pixel side
  input  wire logic [20:0] pixel_parallel_in_i,
  input  wire logic        pixel_clock_in_i,
  input  wire logic        power_down_n_i,
  // Serial data pairs
  output logic      [2:0]  serial_data_pair_p_o,
  output logic      [2:0]  serial_data_pair_n_o,
  // Forwarded link clock pair
  output logic             forwarded_link_clock_p_o,
  output logic             forwarded_link_clock_n_o,
  // Output enable for all pairs
  output logic             serial_oe_o,
  // Status
  output logic             pll_locked_o
);
  localparam int unsigned NL = plsz_pkg::NUM_LINES;
  localparam int unsigned NC = plsz_pkg::NUM_CHANNELS;
  localparam int unsigned NS = plsz_pkg::SLOTS;
  localparam int unsigned LW = $clog2(LOCK_CYCLES + 1);
  localparam int unsigned IW = $clog2(IDLE_CYCLES + 1);
  localparam int unsigned DW = $clog2(SLOT_DIV + 1);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    plsz_pkg::plsz_link_e link;
    logic                 clk_prev;
    logic [LW-1:0]        lock_cnt;
    logic [IW-1:0]        idle_cnt;
    logic                 running;
    logic [2:0]           slot;
    logic [DW-1:0]        div_cnt;
    logic [NL-1:0]        shift;
    logic [NC-1:0]        data_p;
    logic [NC-1:0]        data_n;
    logic                 clk_p;
    logic                 clk_n;
    logic                 oe;
    logic                 locked;
  } plsz_state_s;

  localparam plsz_state_s ST_RESET = '0;

  plsz_state_s   st;
  plsz_state_s   next_st;
  logic [NL+1:0] pins_s;
  logic [NL-1:0] pix_word;
  logic          pix_clk_s;
  logic          pd_n_s;
  logic          fall;
  logic          slot_tick;
  logic          clk_active;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Data and clock share one chain so the word seen at the detected
  // falling edge is the one the controller set up before it.
  plsz_sync #(
    .WIDTH (NL + 2)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({power_down_n_i, pixel_clock_in_i, pixel_parallel_in_i}),
    .sync_o    (pins_s)
  );

  assign pix_word  = pins_s[NL-1:0];
  assign pix_clk_s = pins_s[NL];
  assign pd_n_s    = pins_s[NL+1];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st    = st;
    fall       = st.clk_prev & ~pix_clk_s;
    slot_tick  = (st.div_cnt == DW'(SLOT_DIV - 1));
    clk_active = (st.idle_cnt != IW'(IDLE_CYCLES));
    next_st.clk_prev = pix_clk_s;

    // The pixel clock counts as present while falls keep arriving.
    if (fall) begin
      next_st.idle_cnt = '0;
    end else if (clk_active) begin
      next_st.idle_cnt = st.idle_cnt + IW'(1);
    end

    // Lock timer stands in for the multiplying PLL.
    case (st.link)
      plsz_pkg::PLSZ_DOWN: begin
        next_st.link     = plsz_pkg::PLSZ_WAIT;
        next_st.lock_cnt = '0;
      end
      plsz_pkg::PLSZ_WAIT: begin
        if (!clk_active) begin
          next_st.lock_cnt = '0;
        end else if (st.lock_cnt == LW'(LOCK_CYCLES - 1)) begin
          next_st.link   = plsz_pkg::PLSZ_LOCKED;
          next_st.locked = 1'b1;
        end else begin
          next_st.lock_cnt = st.lock_cnt + LW'(1);
        end
      end
      plsz_pkg::PLSZ_LOCKED: begin
        if (!clk_active) begin
          next_st.link     = plsz_pkg::PLSZ_WAIT;
          next_st.locked   = 1'b0;
          next_st.lock_cnt = '0;
          next_st.running  = 1'b0;
          next_st.data_p   = '0;
          next_st.clk_p    = 1'b0;
        end
      end
      default: begin
        next_st = ST_RESET;
      end
    endcase

    // Slot divider restarts on every fall so slot 0 lines up with it.
    if (fall || slot_tick) begin
      next_st.div_cnt = '0;
    end else begin
      next_st.div_cnt = st.div_cnt + DW'(1);
    end

    // Serializer: a new fall cuts short any word still in flight.
    if (st.link == plsz_pkg::PLSZ_LOCKED && clk_active && fall) begin
      next_st.shift   = pix_word;
      next_st.slot    = '0;
      next_st.running = 1'b1;
      next_st.clk_p   = 1'b1;
      for (int c = 0; c < NC; c++) begin
        next_st.data_p[c] = pix_word[c*NS];
      end
    end else if (st.running && slot_tick) begin
      if (st.slot == 3'(plsz_pkg::LAST_SLOT)) begin
        next_st.running = 1'b0;
      end else begin
        next_st.slot  = st.slot + 3'h1;
        next_st.clk_p = ((st.slot + 3'h1) <
                         3'(plsz_pkg::CLK_HIGH_SLOTS));
        for (int c = 0; c < NC; c++) begin
          next_st.shift[c*NS +: NS] =
            {1'b0, st.shift[c*NS+1 +: NS-1]};
          next_st.data_p[c] = st.shift[c*NS+1];
        end
      end
    end

    next_st.oe     = 1'b1;
    next_st.data_n = ~next_st.data_p;
    next_st.clk_n  = ~next_st.clk_p;

    // Power-down clears everything, negative legs too, so a released
    // pair never shows a driven level; the synchroniser plus this
    // register keep the path to tristate well under the allowed delay.
    if (!pd_n_s) begin
      next_st = ST_RESET;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign serial_data_pair_p_o     = st.data_p;
  assign serial_data_pair_n_o     = st.data_n;
  assign forwarded_link_clock_p_o = st.clk_p;
  assign forwarded_link_clock_n_o = st.clk_n;
  assign serial_oe_o              = st.oe;
  assign pll_locked_o             = st.locked;
endmodule
`default_nettype wire

// ### shared/plsz_pkg.sv
// Constants and types shared by the pixel link serializer.
`default_nettype none
package plsz_pkg;
  // ****************************************************************
  // Link shape
  // ****************************************************************
  localparam int unsigned NUM_LINES      = 21;
  localparam int unsigned NUM_CHANNELS   = 3;
  localparam int unsigned SLOTS          = 7;
  localparam int unsigned CLK_HIGH_SLOTS = 4;
  localparam int unsigned LAST_SLOT      = SLOTS - 1;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned SYS_CLK_HZ      = 50_000_000;
  localparam int unsigned PLL_LOCK_MS     = 10;
  localparam int unsigned PLL_LOCK_CYCLES =
    PLL_LOCK_MS * (SYS_CLK_HZ / 1000);
  localparam int unsigned PD_DELAY_NS     = 100;
  localparam int unsigned PD_DELAY_CYCLES =
    (PD_DELAY_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned REF_PIXEL_MHZ   = 65;
  localparam int unsigned REF_SLOT_PS     = 2200;
  localparam int unsigned SLOT_DIV        = 1;
  localparam int unsigned IDLE_CYCLES     = 64;
  localparam int unsigned SYNC_RESET      = 0;
  // ****************************************************************
  // Link states
  // ****************************************************************
  typedef enum logic [1:0] {
    PLSZ_DOWN,
    PLSZ_WAIT,
    PLSZ_LOCKED
  } plsz_link_e;
endpackage
`default_nettype wire

// ### hdl/plsz_sync.sv
// Two-stage synchroniser for pins that arrive from outside the clock domain.
`default_nettype none
module plsz_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  // Pins
  input  wire logic [WIDTH-1:0] async_i,
  // Synchronised levels
  output logic      [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } plsz_sync_s;

  plsz_sync_s st;
  plsz_sync_s next_st;

  // The first stage feeds only the second stage.
  always_comb begin
    next_st.stage1 = async_i;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= {(2*WIDTH){plsz_pkg::SYNC_RESET[0]}};
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.stage2;
endmodule
`default_nettype wire

// ### dv/plsz_rx_model.sv
// Receiver model that rebuilds pixel words from the serial pairs.
`default_nettype none
module plsz_rx_model (
  // Clock
  input  wire logic        clk_sys_i,
  // Resolved serial wires
  input  wire logic [2:0]  data_p_i,
  input  wire logic        link_clk_p_i,
  // Rebuilt word
  output logic      [20:0] word_o,
  output logic             done_o
);
  logic       clk_q = 1'b0;
  logic [2:0] slot  = 3'h7;
  // A released pair reads as z and so never starts a word.
  always @(posedge clk_sys_i) begin
    done_o <= 1'b0;
    clk_q  <= link_clk_p_i === 1'b1;
    if (link_clk_p_i === 1'b1 && !clk_q) begin
      slot <= 3'h1;
      for (int c = 0; c < 3; c++) word_o[c*7] <= data_p_i[c];
    end else if (slot < 3'h7) begin
      for (int c = 0; c < 3; c++) word_o[c*7+slot] <= data_p_i[c];
      slot   <= slot + 3'h1;
      done_o <= slot == 3'h6;
    end
  end
endmodule
`default_nettype wire

// ### dv/plsz_monitor.sv
// Assertion checker bound to the pixel link serializer.
`default_nettype none
module plsz_monitor (
  // Watched ports
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic [20:0] pixel_parallel_in_i,
  input wire logic        pixel_clock_in_i,
  input wire logic        power_down_n_i,
  input wire logic [2:0]  serial_data_pair_p_o,
  input wire logic [2:0]  serial_data_pair_n_o,
  input wire logic        forwarded_link_clock_p_o,
  input wire logic        forwarded_link_clock_n_o,
  input wire logic        serial_oe_o,
  input wire logic        pll_locked_o
);
  wire logic [2:0] dp = serial_data_pair_p_o;
  wire logic       cp = forwarded_link_clock_p_o;
  wire logic       oe = serial_oe_o;
  logic     [20:0] px1;
  logic     [20:0] px2;
  // Lines pass two synchroniser stages before they are sampled.
  always_ff @(posedge clk_sys_i) begin
    px1 <= pixel_parallel_in_i;
    px2 <= px1;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_data_diff; oe |-> serial_data_pair_n_o == ~dp; endproperty
  a_data_diff: assert property (p_data_diff)
    else $error("data pair legs not complementary");
  property p_clk_diff; oe |-> forwarded_link_clock_n_o == !cp; endproperty
  a_clk_diff: assert property (p_clk_diff)
    else $error("clock pair legs not complementary");
  property p_quiet;
    !oe |-> dp == 3'h0 && !cp && serial_data_pair_n_o == 3'h0
      && !forwarded_link_clock_n_o;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("outputs active while disabled");
  property p_pd_fast; $fell(power_down_n_i) |-> ##[1:5] !oe; endproperty
  a_pd_fast: assert property (p_pd_fast)
    else $error("power-down too slow");
  property p_lock_wait; $rose(oe) |-> !pll_locked_o [*8]; endproperty
  a_lock_wait: assert property (p_lock_wait)
    else $error("lock reported too early");
  property p_no_send; !pll_locked_o |-> !cp; endproperty
  a_no_send: assert property (p_no_send)
    else $error("link clock sent before lock");
  property p_clk_shape; $rose(cp) |-> cp [*4] ##1 !cp [*3]; endproperty
  a_clk_shape: assert property (p_clk_shape)
    else $error("link clock shape wrong");
  property p_slot0; $rose(cp) |-> dp == {px2[14], px2[7], px2[0]}; endproperty
  a_slot0: assert property (p_slot0)
    else $error("slot 0 bits wrong");
  property p_slot4;
    $rose(cp) |-> ##4 dp == {px2[18], px2[11], px2[4]};
  endproperty
  a_slot4: assert property (p_slot4)
    else $error("slot 4 bits wrong");
  c_word: cover property ($rose(cp));
  c_pd:   cover property ($fell(oe));
  c_lock: cover property ($rose(pll_locked_o));
endmodule
bind plsz_serializer plsz_monitor u_mon (.clk_sys_i, .rst_n_i,
  .pixel_parallel_in_i, .pixel_clock_in_i, .power_down_n_i,
  .serial_data_pair_p_o, .serial_data_pair_n_o, .forwarded_link_clock_p_o,
  .forwarded_link_clock_n_o, .serial_oe_o, .pll_locked_o);
`default_nettype wire

// ### dv/testbench.sv
// Self-checking testbench for the pixel link serializer.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [20:0] pixel_parallel_in_i = 21'h000000;
  logic        pixel_clock_in_i = 1'b0;
  logic        power_down_n_i = 1'b1;
  logic [2:0]  dp, dn, dp_w;
  logic        cp, cn, oe, locked, cp_w, rx_done;
  logic [20:0] rx_word;
  int          n_fail = 0;
  int          comparisons = 0;
  int          seed = 41;
  // Disabled pairs float, so the receiver sees z, never a stale level.
  assign dp_w = oe ? dp : 3'hz;
  assign cp_w = oe ? cp : 1'bz;
  plsz_serializer #(.LOCK_CYCLES(50)) DUT (.clk_sys_i, .rst_n_i,
    .pixel_parallel_in_i, .pixel_clock_in_i, .power_down_n_i,
    .serial_data_pair_p_o(dp), .serial_data_pair_n_o(dn),
    .forwarded_link_clock_p_o(cp), .forwarded_link_clock_n_o(cn),
    .serial_oe_o(oe), .pll_locked_o(locked));
  plsz_rx_model u_rx (.clk_sys_i, .data_p_i(dp_w), .link_clk_p_i(cp_w),
    .word_o(rx_word), .done_o(rx_done));
  task automatic chk(input string what, input logic [20:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("Checks %0d, errors %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic send(input logic [20:0] w, input bit check);
    @(posedge clk_sys_i);
    pixel_parallel_in_i <= w;
    pixel_clock_in_i    <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    pixel_clock_in_i <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_sys_i);
      #1;
      if (rx_done) break;
    end
    if (check) chk("word", w, rx_done ? rx_word : ~w);
    if (check && rx_done !== 1'b1) end_sim();
  endtask
  // Words sent before lock are not checked: the link may not be up.
  task automatic lock_up;
    for (int i = 0; i < 40 && locked !== 1'b1; i++)
      send(21'($random(seed)), 1'b0);
    if (locked !== 1'b1) begin
      n_fail++;
      end_sim();
    end
  endtask
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    logic [20:0] corner [5];
    corner = '{21'h000000, 21'h1fffff, 21'h155555, 21'h0aaaaa, 21'h100001};
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    chk("idle", 21'h0, {11'h0, dp, dn, cp, cn, oe, locked});
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk("enable", 21'h000003, {19'h0, oe, cn});
    lock_up();
    foreach (corner[i]) send(corner[i], 1'b1);
    repeat (20) send(21'($random(seed)), 1'b1);
    @(posedge clk_sys_i);
    power_down_n_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    #1;
    chk("power_down", 21'h0, {11'h0, dp, dn, cp, cn, oe, locked});
    @(posedge clk_sys_i);
    power_down_n_i <= 1'b1;
    lock_up();
    send(21'h0f0f0f, 1'b1);
    // A stopped pixel clock must drop lock and silence the link clock.
    repeat (plsz_pkg::IDLE_CYCLES + 16) @(posedge clk_sys_i);
    #1;
    chk("clock_lost", 21'h000000, {19'h0, cp, locked});
    end_sim();
  end
endmodule
`default_nettype wire
